/* rtl/orsq_sequencer.v */
// Operation
// - 10h/18h home run until completion condition
// - Modes 12h/1Ah leave, 15h/1Dh search home
// - Home polarity bit: 0 low, 1 high
// - Index edge select: 0 falling, 1 rising
// - Index count field n selects pulse n+1
// - Limit polarity pin: low active-high limits
// - Limit active: stop now or decelerate
// - Live home, index, limit status readable
// - Filter ignores pulses under 4 us
// - Origin found in 10h/18h and search runs clears counters, pulses deviation clear; leave modes clear nothing
// - Separate clear enables for both counters
// - Auto enable emits deviation clear pulse
// - Method 0 stops on home active
// - Method 1 back off, creep back, stop
// - Methods 2,3 home then index count
// - Methods 4,5 back off then index count
// - Method 6 back off, stop on release
// - Method 7 back off then index count
// - Method 8 counts index after limit releases
// - Methods 9-12 then move to zero
// - Mechanical counter counts only ticks seen while pulses are enabled
`include "orsq_consts.vh"
module orsq_sequencer #(
    parameter FILTER_CYCLES = `ORSQ_FILTER_CYC,
    parameter ERC_CYCLES = `ORSQ_ERC_CYC
) (
    input wire clock,
    input wire resetn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire homeInput,
    input wire encoder_index_input,
    input wire positive_limit_input,
    input wire negative_limit_input,
    input wire limitPolarityPin,
    input wire pulseTick,
    output reg pulseEnable,
    output reg pulseDirection,
    output reg creepSpeed,
    output reg decelStop,
    output reg deviation_clear_output
);
    localparam ST_IDLE = 4'h0;
    localparam ST_SEEK = 4'h1;
    localparam ST_BACK = 4'h2;
    localparam ST_FWD = 4'h3;
    localparam ST_INDEX = 4'h4;
    localparam ST_ZERO = 4'h5;
    localparam ST_LEAVE = 4'h6;
    localparam ST_DONE = 4'h7;
    localparam ST_SRCHREV = 4'h8;

    reg [7:0] operating_mode_code;
    reg [31:0] environment_config_one;
    reg [31:0] environment_config_two;
    reg [31:0] environment_config_three;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] method_reg;
    reg dirNeg_reg;
    reg [4:0] indexCount_reg;
    reg indexArmed_reg;
    reg signed [31:0] commandCount_reg;
    reg signed [31:0] mechCount_reg;
    reg [15:0] ercTimer_reg;
    reg [2:0] indexSync_reg;
    reg homeLast_reg;
    reg limitLast_reg;
    reg startPulse;
    reg stopPulse;
    reg clearNow;
    reg searchMode_reg;
    reg searchFlipped_reg;

    wire homeRaw;
    wire posRaw;
    wire negRaw;
    wire home_polarity_bit = environment_config_one[`ORSQ_ENV1_ORGL];
    wire limit_stop_method_bit = environment_config_one[`ORSQ_ENV1_ELM];
    wire auto_deviation_clear_enable = environment_config_one[`ORSQ_ENV1_EROE];
    wire sensor_filter_disable = environment_config_one[`ORSQ_ENV1_FLTR];
    wire index_edge_select = environment_config_two[`ORSQ_ENV2_EZL];
    wire [3:0] index_count_field = environment_config_three[7:4];
    wire [3:0] homing_method_field = environment_config_three[3:0];
    wire command_count_clear_enable = environment_config_three[`ORSQ_ENV3_CU1R];
    wire mechanical_count_clear_enable = environment_config_three[`ORSQ_ENV3_CU2R];

    orsq_input_filter #(.CYCLES(FILTER_CYCLES)) homeFilter (
        .clock(clock), .resetn(resetn), .pinIn(homeInput),
        .bypass(sensor_filter_disable), .level(homeRaw));
    orsq_input_filter #(.CYCLES(FILTER_CYCLES)) posFilter (
        .clock(clock), .resetn(resetn), .pinIn(positive_limit_input),
        .bypass(sensor_filter_disable), .level(posRaw));
    orsq_input_filter #(.CYCLES(FILTER_CYCLES)) negFilter (
        .clock(clock), .resetn(resetn), .pinIn(negative_limit_input),
        .bypass(sensor_filter_disable), .level(negRaw));

    wire homeActive = home_polarity_bit ? homeRaw : ~homeRaw;
    wire posActive = limitPolarityPin ? ~posRaw : posRaw;
    wire negActive = limitPolarityPin ? ~negRaw : negRaw;
    wire indexLevel = indexSync_reg[2];
    wire indexActive = index_edge_select ? indexLevel : ~indexLevel;
    // Second and third stages agree on a new level before the edge counts
    wire indexEdge = (indexSync_reg[1] == indexSync_reg[2]) && (indexSync_reg[2] != homeLast_reg)
        && (index_edge_select ? indexSync_reg[2] : ~indexSync_reg[2]);
    wire fwdLimit = dirNeg_reg ? negActive : posActive;
    wire homeRise = homeActive & ~limitLast_reg;
    wire homeFall = ~homeActive & limitLast_reg;
    wire indexDone = indexEdge && (indexCount_reg == {1'b0, index_count_field});
    wire searchStart = operating_mode_code == `ORSQ_MOD_SRCH_P
        || operating_mode_code == `ORSQ_MOD_SRCH_N;
    wire startNeg = operating_mode_code[3];

    function isHomingMode;
        input [7:0] code;
        begin
            isHomingMode = (code == `ORSQ_MOD_RET_P) || (code == `ORSQ_MOD_RET_N)
                || (code == `ORSQ_MOD_LEAVE_P) || (code == `ORSQ_MOD_LEAVE_N)
                || (code == `ORSQ_MOD_SRCH_P) || (code == `ORSQ_MOD_SRCH_N);
        end
    endfunction

    function [3:0] baseMethod;
        input [3:0] m;
        begin
            case (m)
                4'h9: baseMethod = 4'h0;
                4'hA: baseMethod = 4'h3;
                4'hB: baseMethod = 4'h5;
                4'hC: baseMethod = 4'h8;
                default: baseMethod = m;
            endcase
        end
    endfunction

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            indexSync_reg <= 3'h0;
            homeLast_reg <= 1'b0;
            limitLast_reg <= 1'b0;
        end else begin
            indexSync_reg <= {indexSync_reg[1:0], encoder_index_input};
            if (indexSync_reg[1] == indexSync_reg[2]) begin
                homeLast_reg <= indexSync_reg[2];
            end
            limitLast_reg <= homeActive;
        end
    end

    // Bus: one wait cycle per access, unmapped reads return zero
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            operating_mode_code <= 8'h00;
            environment_config_one <= 32'h00000000;
            environment_config_two <= 32'h00000000;
            environment_config_three <= 32'h00000000;
            startPulse <= 1'b0;
            stopPulse <= 1'b0;
        end else begin
            startPulse <= 1'b0;
            stopPulse <= 1'b0;
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                if (avs_write) begin
                    case (avs_address)
                        `ORSQ_ADDR_CTRL: begin
                            operating_mode_code <= avs_writedata[15:8];
                            startPulse <= avs_writedata[`ORSQ_CTRL_START];
                            stopPulse <= avs_writedata[`ORSQ_CTRL_STOP];
                        end
                        `ORSQ_ADDR_ENV1: environment_config_one <= avs_writedata;
                        `ORSQ_ADDR_ENV2: environment_config_two <= avs_writedata;
                        `ORSQ_ADDR_ENV3: environment_config_three <= avs_writedata;
                        default: ;
                    endcase
                end else begin
                    case (avs_address)
                        `ORSQ_ADDR_CTRL: avs_readdata <= {16'h0000, operating_mode_code, 8'h00};
                        `ORSQ_ADDR_ENV1: avs_readdata <= environment_config_one;
                        `ORSQ_ADDR_ENV2: avs_readdata <= environment_config_two;
                        `ORSQ_ADDR_ENV3: avs_readdata <= environment_config_three;
                        `ORSQ_ADDR_STAT: avs_readdata <= {23'h000000, pulseEnable, state_reg,
                            negActive, posActive, indexActive, homeActive};
                        `ORSQ_ADDR_CNT1: avs_readdata <= commandCount_reg;
                        `ORSQ_ADDR_CNT2: avs_readdata <= mechCount_reg;
                        default: avs_readdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    always @* begin
        state_next = state_reg;
        clearNow = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (startPulse && isHomingMode(operating_mode_code)) begin
                    if (operating_mode_code == `ORSQ_MOD_LEAVE_P
                        || operating_mode_code == `ORSQ_MOD_LEAVE_N) begin
                        state_next = homeActive ? ST_LEAVE : ST_IDLE;
                    end else if (searchStart && homeActive) begin
                        state_next = ST_LEAVE;
                    end else begin
                        state_next = ST_SEEK;
                    end
                end
            end
            ST_SEEK: begin
                if (homeRise) begin
                    case (baseMethod(method_reg))
                        4'h0: begin
                            clearNow = 1'b1;
                            state_next = method_reg == 4'h0 ? ST_DONE : ST_ZERO;
                        end
                        4'h2, 4'h3: state_next = ST_INDEX;
                        default: state_next = ST_BACK;
                    endcase
                end else if (fwdLimit && searchMode_reg && !searchFlipped_reg) begin
                    state_next = ST_SRCHREV;
                end
            end
            ST_BACK: begin
                // Reverse at creep speed until home releases, or for method 8 bases until the limit releases
                if (baseMethod(method_reg) == 4'h8) begin
                    if (!fwdLimit) state_next = ST_INDEX;
                end else if (homeFall) begin
                    case (baseMethod(method_reg))
                        4'h1: state_next = ST_FWD;
                        4'h6: begin
                            clearNow = !fwdLimit;
                            state_next = ST_DONE;
                        end
                        default: state_next = ST_INDEX;
                    endcase
                end
            end
            ST_FWD: begin
                if (homeRise) begin
                    clearNow = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_INDEX: begin
                if (indexDone) begin
                    clearNow = 1'b1;
                    state_next = method_reg >= 4'h9 ? ST_ZERO : ST_DONE;
                end
            end
            ST_ZERO: begin
                if (mechCount_reg == 32'sh00000000) state_next = ST_DONE;
            end
            ST_LEAVE: begin
                if (!homeActive) state_next = searchMode_reg ? ST_SEEK : ST_DONE;
            end
            ST_SRCHREV: begin
                if (homeRise) state_next = ST_LEAVE;
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (stopPulse) state_next = ST_IDLE;
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            method_reg <= 4'h0;
            dirNeg_reg <= 1'b0;
            indexCount_reg <= 5'h00;
            commandCount_reg <= 32'sh00000000;
            mechCount_reg <= 32'sh00000000;
            ercTimer_reg <= 16'h0000;
            searchMode_reg <= 1'b0;
            searchFlipped_reg <= 1'b0;
            pulseEnable <= 1'b0;
            pulseDirection <= 1'b0;
            creepSpeed <= 1'b0;
            decelStop <= 1'b0;
            deviation_clear_output <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
                method_reg <= homing_method_field;
                dirNeg_reg <= startNeg;
                searchMode_reg <= searchStart;
                searchFlipped_reg <= 1'b0;
                indexCount_reg <= 5'h00;
            end else if (state_next != state_reg) begin
                indexCount_reg <= 5'h00;
                if (state_next == ST_SRCHREV) searchFlipped_reg <= 1'b1;
            end else if (state_reg == ST_INDEX && indexEdge) begin
                indexCount_reg <= indexCount_reg + 5'h01;
            end
            // Counters count ticks only while pulses are enabled; a clear wins over a tick in the same cycle
            if (clearNow) begin
                if (command_count_clear_enable) commandCount_reg <= 32'sh00000000;
                if (mechanical_count_clear_enable) mechCount_reg <= 32'sh00000000;
            end else if (pulseTick && pulseEnable) begin
                commandCount_reg <= pulseDirection ? commandCount_reg - 32'sh00000001
                    : commandCount_reg + 32'sh00000001;
                mechCount_reg <= pulseDirection ? mechCount_reg - 32'sh00000001
                    : mechCount_reg + 32'sh00000001;
            end
            if (clearNow && auto_deviation_clear_enable) begin
                ercTimer_reg <= ERC_CYCLES;
            end else if (ercTimer_reg != 16'h0000) begin
                ercTimer_reg <= ercTimer_reg - 16'h0001;
            end
            deviation_clear_output <= (clearNow && auto_deviation_clear_enable)
                || ercTimer_reg > 16'h0001;
            pulseEnable <= state_next != ST_IDLE && state_next != ST_DONE
                && !(fwdLimit && state_next == state_reg && state_reg != ST_BACK);
            decelStop <= fwdLimit && limit_stop_method_bit;
            creepSpeed <= state_next == ST_BACK || state_next == ST_FWD
                || state_next == ST_LEAVE;
            case (state_next)
                ST_BACK, ST_SRCHREV: begin
                    pulseDirection <= ~dirNeg_reg;
                end
                // Search leaves home against the requested direction, plain leave goes with it
                ST_LEAVE: begin
                    pulseDirection <= searchMode_reg ? ~dirNeg_reg : dirNeg_reg;
                end
                ST_ZERO: begin
                    pulseDirection <= mechCount_reg > 32'sh00000000;
                end
                default: begin
                    pulseDirection <= dirNeg_reg;
                end
            endcase
        end
    end
endmodule

/* rtl/orsq_consts.vh */
`ifndef ORSQ_CONSTS_VH
`define ORSQ_CONSTS_VH
`define ORSQ_ADDR_CTRL 4'h0
`define ORSQ_ADDR_ENV1 4'h1
`define ORSQ_ADDR_ENV2 4'h2
`define ORSQ_ADDR_ENV3 4'h3
`define ORSQ_ADDR_STAT 4'h4
`define ORSQ_ADDR_CNT1 4'h5
`define ORSQ_ADDR_CNT2 4'h6
`define ORSQ_MOD_RET_P 8'h10
`define ORSQ_MOD_RET_N 8'h18
`define ORSQ_MOD_LEAVE_P 8'h12
`define ORSQ_MOD_LEAVE_N 8'h1A
`define ORSQ_MOD_SRCH_P 8'h15
`define ORSQ_MOD_SRCH_N 8'h1D
`define ORSQ_ENV1_ORGL 0
`define ORSQ_ENV1_ELM 1
`define ORSQ_ENV1_EROE 2
`define ORSQ_ENV1_FLTR 3
`define ORSQ_ENV2_EZL 0
`define ORSQ_ENV3_CU1R 8
`define ORSQ_ENV3_CU2R 9
`define ORSQ_CTRL_START 0
`define ORSQ_CTRL_STOP 1
`define ORSQ_CTRL_HISPD 2
`define ORSQ_FILTER_NS 4000
`define ORSQ_CLK_NS 8
`define ORSQ_FILTER_CYC ((`ORSQ_FILTER_NS + `ORSQ_CLK_NS - 1) / `ORSQ_CLK_NS)
`define ORSQ_ERC_CYC 16'h0010
`endif

/* rtl/orsq_input_filter.v */
`include "orsq_consts.vh"
module orsq_input_filter #(
    parameter CYCLES = `ORSQ_FILTER_CYC
) (
    input wire clock,
    input wire resetn,
    input wire pinIn,
    input wire bypass,
    output reg level
);
    reg [2:0] sync_reg;
    reg [9:0] count_reg;
    wire agreed;
    assign agreed = sync_reg[2];
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= 3'h0;
            count_reg <= 10'h000;
            level <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], pinIn};
            // Change counts only when second and third stages agree
            if (sync_reg[1] != sync_reg[2]) begin
                count_reg <= 10'h000;
            end else if (agreed == level) begin
                count_reg <= 10'h000;
            end else if (bypass || count_reg >= CYCLES[9:0] - 10'h001) begin
                level <= agreed;
                count_reg <= 10'h000;
            end else begin
                count_reg <= count_reg + 10'h001;
            end
        end
    end
endmodule

/* verification/orsq_seq_chk.sv */
module orsq_seq_chk #(
    parameter ERC_CYCLES = 16
) (
    input logic clock,
    input logic resetn,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic pulseEnable,
    input logic pulseDirection,
    input logic deviation_clear_output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ercRun_reg;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ercRun_reg <= 16'h0000;
        end else if (deviation_clear_output) begin
            ercRun_reg <= ercRun_reg + 16'h0001;
        end else begin
            ercRun_reg <= 16'h0000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence reqTaken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence ctrlWr;
        avs_write && avs_waitrequest && avs_address == 4'h0;
    endsequence
    // Search modes are left out: they may leave home against the requested direction
    sequence startPos;
        ctrlWr ##0 (avs_writedata[0]
            && (avs_writedata[15:8] == 8'h10 || avs_writedata[15:8] == 8'h12));
    endsequence
    sequence startNeg;
        ctrlWr ##0 (avs_writedata[0]
            && (avs_writedata[15:8] == 8'h18 || avs_writedata[15:8] == 8'h1A));
    endsequence
    AST_START_POS: assert property (startPos |-> ##6 (!pulseEnable || !pulseDirection))
        else $error("Positive home mode ran negative");
    AST_START_NEG: assert property (startNeg |-> ##6 (!pulseEnable || pulseDirection))
        else $error("Negative home mode ran positive");
    AST_STOP: assert property (ctrlWr ##0 avs_writedata[1] |-> ##[1:4] !pulseEnable)
        else $error("Stop command did not halt pulses");
    AST_RESET_IDLE: assert property ($rose(resetn) |-> !pulseEnable && !deviation_clear_output)
        else $error("Outputs not idle after reset");
    AST_ERC_LEN: assert property (ercRun_reg <= ERC_CYCLES)
        else $error("Deviation clear pulse too long");
    AST_ANSWER: assert property (reqTaken |=> !avs_waitrequest)
        else $error("Bus request not answered next cycle");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request low for more than one cycle");
    AST_NO_SPONT: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("Answer without a request");
    AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address > 4'h6
        |=> avs_readdata == 32'h00000000)
        else $error("Unmapped read returned data");
endmodule
bind orsq_sequencer orsq_seq_chk #(.ERC_CYCLES(ERC_CYCLES)) u_orsq_seq_chk (
    .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pulseEnable(pulseEnable),
    .pulseDirection(pulseDirection), .deviation_clear_output(deviation_clear_output));

/* verification/orsq_axis_model.sv */
module orsq_axis_model (
    input logic clock,
    input logic resetn,
    input logic pulseEnable,
    input logic pulseDirection,
    input logic creepSpeed,
    input logic limitPolarityPin,
    input logic forceLim,
    output logic pulseTick,
    output logic homeInput,
    output logic encoder_index_input,
    output logic positive_limit_input,
    output logic negative_limit_input,
    output logic inHome
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [15:0] pos;
    logic [2:0] div;
    logic limPos;
    logic limNeg;
    assign inHome = (pos >= 20 && pos <= 40) || (pos >= -40 && pos <= -20);
    // Switch drives high when active; the bench sets the polarity bit to match
    assign homeInput = inHome;
    // One index mark per eight steps, held a whole step so the synchroniser sees it
    assign encoder_index_input = pos[2:0] == 3'h0;
    assign limPos = pos >= 100 || forceLim;
    assign limNeg = pos <= -100 || forceLim;
    assign positive_limit_input = limitPolarityPin ? !limPos : limPos;
    assign negative_limit_input = limitPolarityPin ? !limNeg : limNeg;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pos <= 16'h0000;
            div <= 3'h0;
            pulseTick <= 1'b0;
        end else begin
            pulseTick <= 1'b0;
            div <= 3'h0;
            // Creep speed halves the step rate, so slow answers get exercised
            if (pulseEnable && div == (creepSpeed ? 3'h7 : 3'h3)) begin
                pulseTick <= 1'b1;
                pos <= pulseDirection ? pos - 16'sh0001 : pos + 16'sh0001;
            end else if (pulseEnable) begin
                div <= div + 3'h1;
            end
        end
    end
endmodule

/* verification/tb_origin_return_sequencer.sv */
module tb_origin_return_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic limitPolarityPin = 1'b0;
    logic forceLim = 1'b0;
    logic idxPrev = 1'b0;
    logic dirSeen = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, homeInput, encoder_index_input, positive_limit_input;
    logic negative_limit_input, pulseTick, pulseEnable, pulseDirection, creepSpeed;
    logic decelStop, deviation_clear_output, inHome;
    int n_errors = 0;
    int n_checks = 0;
    int ercHigh = 0;
    int idxCnt = 0;
    initial begin
        forever #4 clock = ~clock;
    end
    orsq_sequencer #(.FILTER_CYCLES(2)) u_orsq_sequencer (
        .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .homeInput(homeInput),
        .encoder_index_input(encoder_index_input), .positive_limit_input(positive_limit_input),
        .negative_limit_input(negative_limit_input), .limitPolarityPin(limitPolarityPin),
        .pulseTick(pulseTick), .pulseEnable(pulseEnable), .pulseDirection(pulseDirection),
        .creepSpeed(creepSpeed), .decelStop(decelStop),
        .deviation_clear_output(deviation_clear_output));
    orsq_axis_model u_orsq_axis_model (
        .clock(clock), .resetn(resetn), .pulseEnable(pulseEnable),
        .pulseDirection(pulseDirection), .creepSpeed(creepSpeed),
        .limitPolarityPin(limitPolarityPin), .forceLim(forceLim), .pulseTick(pulseTick),
        .homeInput(homeInput), .encoder_index_input(encoder_index_input),
        .positive_limit_input(positive_limit_input),
        .negative_limit_input(negative_limit_input), .inHome(inHome));
    always @(posedge clock) begin
        idxPrev <= encoder_index_input;
        if (deviation_clear_output === 1'b1) ercHigh <= ercHigh + 1;
        if (pulseEnable === 1'b1) dirSeen <= dirSeen | pulseDirection;
        if (pulseEnable && inHome && encoder_index_input && !idxPrev) idxCnt <= idxCnt + 1;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 100);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i >= 100) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic readStat;
        repeat (10) @(posedge clock);
        busOp(1'b0, 4'h4, 32'h00000000);
    endtask
    // Start a mode and wait, bounded, until the pulse request drops again
    task automatic run(input logic [7:0] mode);
        int i;
        ercHigh = 0;
        idxCnt = 0;
        dirSeen = 1'b0;
        busOp(1'b1, 4'h0, {16'h0000, mode, 8'h01});
        repeat (8) @(posedge clock);
        i = 0;
        while (pulseEnable !== 1'b0 && i < 4000) begin
            @(posedge clock);
            i++;
        end
        if (i >= 4000) begin
            n_errors++;
            conclude();
        end
        repeat (30) @(posedge clock);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("waitrequest", avs_waitrequest, 1);
        check("pulseEnable", pulseEnable, 0);
        busOp(1'b0, 4'hF, 32'h00000000);
        check("unmapped", rd, 0);
        busOp(1'b1, 4'h1, 32'h00000005);
        busOp(1'b1, 4'h2, 32'h00000001);
        busOp(1'b1, 4'h3, 32'h00000100);
        run(8'h10);
        check("dirHome", dirSeen, 0);
        check("ercAuto", ercHigh > 0, 1);
        busOp(1'b0, 4'h5, 32'h00000000);
        check("cmdClear", rd < 4, 1);
        busOp(1'b0, 4'h6, 32'h00000000);
        check("mechKept", rd >= 20 && rd < 24, 1);
        readStat();
        check("homeHigh", rd[0], 1);
        busOp(1'b1, 4'h1, 32'h00000004);
        readStat();
        check("homeLow", rd[0], 0);
        busOp(1'b1, 4'h1, 32'h00000001);
        run(8'h1A);
        check("dirLeave", dirSeen, 1);
        check("leftHome", inHome, 0);
        busOp(1'b1, 4'h3, 32'h00000112);
        run(8'h10);
        check("indexCount", idxCnt, 2);
        check("ercOff", ercHigh, 0);
        busOp(1'b0, 4'h5, 32'h00000000);
        check("cmdClearIdx", rd < 4, 1);
        busOp(1'b1, 4'h0, 32'h00001201);
        repeat (4) @(posedge clock);
        check("creepLeave", creepSpeed, 1);
        check("dirLeaveP", pulseDirection, 0);
        busOp(1'b1, 4'h0, 32'h00000002);
        repeat (6) @(posedge clock);
        check("stopped", pulseEnable, 0);
        check("stillHome", inHome, 1);
        forceLim <= 1'b1;
        readStat();
        check("limActHigh", rd[3:2], 3);
        limitPolarityPin <= 1'b1;
        readStat();
        check("limActLow", rd[3:2], 3);
        busOp(1'b1, 4'h1, 32'h00000003);
        repeat (2) @(posedge clock);
        check("decelStop", decelStop, 1);
        forceLim <= 1'b0;
        readStat();
        check("limOff", rd[3:2], 0);
        check("decelOff", decelStop, 0);
        conclude();
    end
endmodule
